// ==== dfl_fault_latch_manager.sv ====
`timescale 1ns/1ns

// How it works
// (RL1) Any fault source drops power enable immediately
// (RL2) Each fault stays latched until reset
// (RL3) Healthy_indicator indicator flashes while any latch set
// (RL4) Fault sets the fault latched flag
// (RL5) Healthy output level follows polarity setting
// (RL6) Power stays off while any latch set
// (RL7) Reset clears latch only if source gone
// (RL8) All sources latch independently and concurrently
// (RL9) Reset from remote input or keypad key
// (RL10) Successful reset: indicator steady on, flag false
// (RL11) New fault presents its cause code
// (RL12) Operator acknowledges message with acknowledge key
// (RL13) Separate bus undervoltage and overvoltage faults
// (RL14) Missing external supply level is a fault
// (RL15) Separate signal break fault per analog input
// (RL16) Keypad unplugged while running locally faults
// (RL17) No traffic within comms timeout faults
// (RL18) Current time integral over settings faults
// (RL19) Distinct current, heat, stall, brake faults
// (RL20) Reset clears inactive latches, keeps active ones
module dfl_fault_latch_manager #(
    parameter int unsigned MS_TICK_CYCLES = dfl_pkg::MS_TICK_CYCLES,
    parameter int unsigned BLINK_HALF_CYCLES = dfl_pkg::BLINK_HALF_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // AXI4-Lite write address and data
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Fault detector levels
    input wire logic dcBusLowDet,
    input wire logic dcBusHighDet,
    input wire logic overCurrentDet,
    input wire logic heatsinkHotDet,
    input wire logic extSupplyPresent,
    input wire logic ain1BreakDet,
    input wire logic ain2BreakDet,
    input wire logic stallDet,
    input wire logic brakeResOverloadDet,
    input wire logic brakeSwOverloadDet,
    // Current measurement and comms activity
    input wire logic [15:0] motorCurrent,
    input wire logic commsValidPulse,
    // Keypad panel and terminals
    input wire logic keypadPresent,
    input wire logic localControl,
    input wire logic remoteResetIn,
    input wire logic keyStopReset,
    input wire logic keyAck,
    // Drive side outputs
    output logic powerEnable,
    output logic healthLed,
    output logic faultLatchedFlag,
    output logic healthyOut,
    output logic [3:0] msgCode,
    output logic msgPending
);

    localparam int NF = dfl_pkg::NUM_FAULTS;

    // Whole module state in one record
    typedef struct packed {
        logic [NF-1:0] latch;       // Latched faults
        logic remPrev;              // Edge detect of remote reset
        logic keyPrev;              // Edge detect of stop/reset key
        logic ackPrev;              // Edge detect of acknowledge key
        logic [23:0] blinkCnt;      // Flash half period counter
        logic blinkPh;              // Flash phase
        logic [15:0] msCnt;         // Millisecond prescaler
        logic [15:0] commsCnt;      // Milliseconds since last traffic
        logic [31:0] i2tAcc;        // Excess current integral
        logic invertHealthy;        // Healthy output polarity
        logic runRequest;           // Software asks for power stage
        logic [15:0] commsTimeout;  // Zero disables comms check
        logic [15:0] i2tThresh;
        logic [15:0] i2tUpper;
        logic [31:0] i2tDur;
        logic [3:0] code;
        logic pend;
        logic powerEn;
        logic led;
        logic flag;
        logic healthy;
        logic awRdy;
        logic wRdy;
        logic awHeld;
        logic wHeld;
        logic [7:0] wAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic arRdy;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
    } dfl_state_t;

    localparam dfl_state_t ST_RESET = '{
        commsTimeout: dfl_pkg::RST_COMMS_TO,
        i2tThresh: dfl_pkg::RST_I2T_THRESH,
        i2tUpper: dfl_pkg::RST_I2T_UPPER,
        i2tDur: dfl_pkg::RST_I2T_DUR,
        led: 1'b1,
        // No latch and normal polarity, so the output already reads healthy
        healthy: 1'b1,
        default: '0
    };

    dfl_state_t s_ff;
    dfl_state_t nxt_s;

    // Raw fault conditions, one bit per source
    logic [NF-1:0] src;
    logic rstEvt;     // Reset request edge
    logic ackEvt;     // Acknowledge key edge
    logic msTick;
    logic [NF-1:0] latchN;

    assign src[dfl_pkg::F_BUS_LOW] = dcBusLowDet; // RL13
    assign src[dfl_pkg::F_BUS_HIGH] = dcBusHighDet; // RL13
    assign src[dfl_pkg::F_OVER_CURRENT] = overCurrentDet; // RL19
    assign src[dfl_pkg::F_HEATSINK] = heatsinkHotDet; // RL19
    // An absent supply level counts as a fault, so a broken wire trips
    assign src[dfl_pkg::F_EXTERNAL] = ~extSupplyPresent; // RL14
    assign src[dfl_pkg::F_AIN1_BREAK] = ain1BreakDet; // RL15
    assign src[dfl_pkg::F_AIN2_BREAK] = ain2BreakDet; // RL15
    assign src[dfl_pkg::F_STALL] = stallDet; // RL19
    // Hard ceiling trips at once, the integral trips over the duration
    assign src[dfl_pkg::F_I2T] = (motorCurrent > s_ff.i2tUpper)
        | (s_ff.i2tAcc > s_ff.i2tDur); // RL18
    assign src[dfl_pkg::F_BRAKE_RES] = brakeResOverloadDet; // RL19
    assign src[dfl_pkg::F_BRAKE_SW] = brakeSwOverloadDet; // RL19
    // Only a running, locally controlled drive needs its keypad
    assign src[dfl_pkg::F_KEYPAD] = ~keypadPresent & s_ff.powerEn & localControl; // RL16
    assign src[dfl_pkg::F_COMMS] = (s_ff.commsTimeout != 16'h0000)
        & (s_ff.commsCnt >= s_ff.commsTimeout); // RL17

    // Either reset source is taken on its rising edge
    assign rstEvt = (remoteResetIn & ~s_ff.remPrev) | (keyStopReset & ~s_ff.keyPrev); // RL9
    assign ackEvt = keyAck & ~s_ff.ackPrev; // RL12
    assign msTick = (32'(s_ff.msCnt) == MS_TICK_CYCLES - 1);

    // Reset keeps whatever is still active; a new event wins over the clear
    assign latchN = rstEvt ? src : (s_ff.latch | src); // RL2 RL7 RL8 RL20

    // Lowest numbered newly latched fault names the cause
    function automatic logic [3:0] firstCode(input logic [NF-1:0] v);
        logic [3:0] c;
        c = 4'h0;
        for (int i = NF - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                c = 4'(i + 1);
            end
        end
        return c;
    endfunction

    // Byte lane merge for register writes
    function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] dat,
        input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                r[b*8 +: 8] = dat[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Read mux over the register map; unmapped answers with an error
    function automatic logic [32:0] readReg(input dfl_state_t s, input logic [7:0] a,
        input logic [NF-1:0] raw);
        logic [32:0] r;
        r = {1'b0, 32'h0000_0000};
        if (a == dfl_pkg::OFS_CTRL)
        begin
            r[dfl_pkg::CTRL_INVERT_BIT] = s.invertHealthy;
            r[dfl_pkg::CTRL_RUN_BIT] = s.runRequest;
        end
        else if (a == dfl_pkg::OFS_LATCH)
        begin
            r[NF-1:0] = s.latch;
        end
        else if (a == dfl_pkg::OFS_SOURCE)
        begin
            r[NF-1:0] = raw;
        end
        else if (a == dfl_pkg::OFS_COMMS_TO)
        begin
            r[15:0] = s.commsTimeout;
        end
        else if (a == dfl_pkg::OFS_I2T_THRESH)
        begin
            r[15:0] = s.i2tThresh;
        end
        else if (a == dfl_pkg::OFS_I2T_UPPER)
        begin
            r[15:0] = s.i2tUpper;
        end
        else if (a == dfl_pkg::OFS_I2T_DUR)
        begin
            r[31:0] = s.i2tDur;
        end
        else if (a == dfl_pkg::OFS_STATUS)
        begin
            r[dfl_pkg::ST_CODE_LSB +: 4] = s.code;
            r[dfl_pkg::ST_PEND_BIT] = s.pend;
            r[dfl_pkg::ST_LATCHED_BIT] = s.flag;
            r[dfl_pkg::ST_POWER_BIT] = s.powerEn;
        end
        else if (a == dfl_pkg::OFS_I2T_ACC)
        begin
            r[31:0] = s.i2tAcc;
        end
        else
        begin
            r[32] = 1'b1;
        end
        return r;
    endfunction

    // Next state of the whole block
    always_comb
    begin
        logic [16:0] diff;
        logic [32:0] sum;
        logic [32:0] rd;
        logic [7:0] wa;
        logic [31:0] wv;
        diff = 17'h0_0000;
        sum = 33'h0_0000_0000;
        rd = 33'h0_0000_0000;
        wa = 8'h00;
        wv = 32'h0000_0000;
        nxt_s = s_ff;
        nxt_s.remPrev = remoteResetIn;
        nxt_s.keyPrev = keyStopReset;
        nxt_s.ackPrev = keyAck;

        // Millisecond prescaler
        nxt_s.msCnt = msTick ? 16'h0000 : s_ff.msCnt + 16'h0001;

        // Traffic restarts the silence count; it saturates rather than wraps
        if (commsValidPulse)
        begin
            nxt_s.commsCnt = 16'h0000; // RL17
        end
        else if (msTick && s_ff.commsCnt != 16'hFFFF)
        begin
            nxt_s.commsCnt = s_ff.commsCnt + 16'h0001; // RL17
        end

        // Integral grows by the excess over threshold and decays below it
        if (motorCurrent > s_ff.i2tThresh)
        begin
            diff = {1'b0, motorCurrent} - {1'b0, s_ff.i2tThresh};
            sum = {1'b0, s_ff.i2tAcc} + {16'h0000, diff};
            nxt_s.i2tAcc = sum[32] ? 32'hFFFF_FFFF : sum[31:0]; // RL18
        end
        else
        begin
            diff = {1'b0, s_ff.i2tThresh} - {1'b0, motorCurrent};
            nxt_s.i2tAcc = (s_ff.i2tAcc > {15'h0000, diff})
                ? s_ff.i2tAcc - {15'h0000, diff} : 32'h0000_0000; // RL18
        end

        // Flash timebase runs freely; phase only shows while fault_latched_flag
        if (32'(s_ff.blinkCnt) == BLINK_HALF_CYCLES - 1)
        begin
            nxt_s.blinkCnt = 24'h00_0000;
            nxt_s.blinkPh = ~s_ff.blinkPh;
        end
        else
        begin
            nxt_s.blinkCnt = s_ff.blinkCnt + 24'h00_0001;
        end

        // Fault latches
        nxt_s.latch = latchN; // RL2 RL8

        // Message code and acknowledge; a new fault wins over an acknowledge
        if (|(latchN & ~s_ff.latch))
        begin
            nxt_s.code = firstCode(latchN & ~s_ff.latch); // RL11
            nxt_s.pend = 1'b1; // RL11
        end
        else if (ackEvt)
        begin
            nxt_s.pend = 1'b0; // RL12
        end
        if (latchN == '0 && !nxt_s.pend)
        begin
            nxt_s.code = 4'h0;
        end

        // AXI write channel capture, address and data in either order
        if (awvalid && s_ff.awRdy)
        begin
            nxt_s.awHeld = 1'b1;
            nxt_s.wAddr = awaddr;
        end
        if (wvalid && s_ff.wRdy)
        begin
            nxt_s.wHeld = 1'b1;
            nxt_s.wData = wdata;
            nxt_s.wStrb = wstrb;
        end
        if (s_ff.bValid && bready)
        begin
            nxt_s.bValid = 1'b0;
        end
        // Perform the write once both halves are held
        if (s_ff.awHeld && s_ff.wHeld && !s_ff.bValid)
        begin
            wa = {s_ff.wAddr[7:2], 2'b00};
            nxt_s.awHeld = 1'b0;
            nxt_s.wHeld = 1'b0;
            nxt_s.bValid = 1'b1;
            nxt_s.bResp = dfl_pkg::RESP_OKAY;
            if (wa == dfl_pkg::OFS_CTRL)
            begin
                wv = mergeStrb({30'h0000_0000, s_ff.runRequest, s_ff.invertHealthy},
                    s_ff.wData, s_ff.wStrb);
                nxt_s.invertHealthy = wv[dfl_pkg::CTRL_INVERT_BIT]; // RL5
                nxt_s.runRequest = wv[dfl_pkg::CTRL_RUN_BIT];
            end
            else if (wa == dfl_pkg::OFS_COMMS_TO)
            begin
                wv = mergeStrb({16'h0000, s_ff.commsTimeout}, s_ff.wData, s_ff.wStrb);
                nxt_s.commsTimeout = wv[15:0]; // RL17
            end
            else if (wa == dfl_pkg::OFS_I2T_THRESH)
            begin
                wv = mergeStrb({16'h0000, s_ff.i2tThresh}, s_ff.wData, s_ff.wStrb);
                nxt_s.i2tThresh = wv[15:0];
            end
            else if (wa == dfl_pkg::OFS_I2T_UPPER)
            begin
                wv = mergeStrb({16'h0000, s_ff.i2tUpper}, s_ff.wData, s_ff.wStrb);
                nxt_s.i2tUpper = wv[15:0];
            end
            else if (wa == dfl_pkg::OFS_I2T_DUR)
            begin
                nxt_s.i2tDur = mergeStrb(s_ff.i2tDur, s_ff.wData, s_ff.wStrb);
            end
            else if (wa == dfl_pkg::OFS_LATCH || wa == dfl_pkg::OFS_SOURCE
                || wa == dfl_pkg::OFS_STATUS || wa == dfl_pkg::OFS_I2T_ACC)
            begin
                // Read-only words ignore writes
                nxt_s.bResp = dfl_pkg::RESP_OKAY;
            end
            else
            begin
                nxt_s.bResp = dfl_pkg::RESP_SLVERR;
            end
        end
        // Readies drop while a half is held or a response waits
        nxt_s.awRdy = ~nxt_s.awHeld & ~nxt_s.bValid;
        nxt_s.wRdy = ~nxt_s.wHeld & ~nxt_s.bValid;

        // AXI read channel
        if (s_ff.rValid && rready)
        begin
            nxt_s.rValid = 1'b0;
        end
        if (arvalid && s_ff.arRdy)
        begin
            rd = readReg(s_ff, {araddr[7:2], 2'b00}, src);
            nxt_s.rValid = 1'b1;
            nxt_s.rData = rd[31:0];
            nxt_s.rResp = rd[32] ? dfl_pkg::RESP_SLVERR : dfl_pkg::RESP_OKAY;
        end
        nxt_s.arRdy = ~nxt_s.rValid;

        // Power stage is gated by live sources as well as latches
        nxt_s.powerEn = nxt_s.runRequest & ~(|latchN) & ~(|src); // RL1 RL6
        nxt_s.flag = |latchN; // RL4 RL10
        nxt_s.led = (|latchN) ? nxt_s.blinkPh : 1'b1; // RL3 RL10
        nxt_s.healthy = ~(|latchN) ^ nxt_s.invertHealthy; // RL5
    end

    // State register with synchronous reset
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            s_ff <= ST_RESET;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    // Outputs straight from the state register
    assign awready = s_ff.awRdy;
    assign wready = s_ff.wRdy;
    assign bvalid = s_ff.bValid;
    assign bresp = s_ff.bResp;
    assign arready = s_ff.arRdy;
    assign rvalid = s_ff.rValid;
    assign rdata = s_ff.rData;
    assign rresp = s_ff.rResp;
    assign powerEnable = s_ff.powerEn;
    assign healthLed = s_ff.led;
    assign faultLatchedFlag = s_ff.flag;
    assign healthyOut = s_ff.healthy;
    assign msgCode = s_ff.code;
    assign msgPending = s_ff.pend;

    // Reset request that finds every source quiet, then a clean state
    sequence sCleanReset;
        rstEvt && (src == '0);
    endsequence
    sequence sAllClear;
        (s_ff.latch == '0) && !faultLatchedFlag && healthLed;
    endsequence

    a_power_off_fault: assert property (@(posedge clk) disable iff (!rst_b) // RL1
        (|src) |=> !powerEnable)
        else $error("power stage stayed on during a fault");
    a_latch_keeps: assert property (@(posedge clk) disable iff (!rst_b) // RL2
        !rstEvt |=> ((s_ff.latch & $past(s_ff.latch)) == $past(s_ff.latch)))
        else $error("latched fault lost without reset");
    a_led_flashes: assert property (@(posedge clk) disable iff (!rst_b) // RL3
        (|s_ff.latch) |-> (healthLed == s_ff.blinkPh))
        else $error("indicator not flashing while fault_latched_flag");
    a_flag_sets: assert property (@(posedge clk) disable iff (!rst_b) // RL4
        (|src) |=> faultLatchedFlag && (s_ff.latch == $past(latchN)))
        else $error("fault latched flag not set");
    a_healthy_level: assert property (@(posedge clk) disable iff (!rst_b) // RL5
        healthyOut == (!faultLatchedFlag ^ s_ff.invertHealthy))
        else $error("healthy output level wrong");
    a_no_enable_fault_latched_flag: assert property (@(posedge clk) disable iff (!rst_b) // RL6
        (|s_ff.latch) |-> !powerEnable)
        else $error("power enabled with a latch set");
    a_active_survives: assert property (@(posedge clk) disable iff (!rst_b) // RL7
        rstEvt |=> ((s_ff.latch & $past(src)) == $past(src)))
        else $error("active fault cleared by reset");
    a_reset_clears_all: assert property (@(posedge clk) disable iff (!rst_b) // RL10
        sCleanReset |=> sAllClear)
        else $error("quiet reset left a trip");
    a_code_shown: assert property (@(posedge clk) disable iff (!rst_b) // RL11
        (s_ff.latch == '0) && (|src) |=> msgPending && (msgCode != 4'h0))
        else $error("no cause code on new fault");
    a_comms_trip: assert property (@(posedge clk) disable iff (!rst_b) // RL17
        (s_ff.commsTimeout != 16'h0000) && (s_ff.commsCnt >= s_ff.commsTimeout)
        |=> s_ff.latch[dfl_pkg::F_COMMS])
        else $error("comms timeout did not latch");

endmodule

// ==== dfl_keypad_panel_model.sv ====
`timescale 1ns/1ns

module dfl_keypad_panel_model (
    // Clock
    input wire logic clk,
    // Reset and acknowledge requests
    output logic remoteResetIn,
    output logic keyStopReset,
    output logic keyAck,
    // Panel attachment and control location
    output logic keypadPresent,
    output logic localControl
);
    // Panel attached, remote control, so the unplug fault stays quiet
    initial
    begin
        remoteResetIn = 1'b0;
        keyStopReset = 1'b0;
        keyAck = 1'b0;
        keypadPresent = 1'b1;
        localControl = 1'b0;
    end

    // One press: low on one edge, high on the next, held two edges
    task automatic press(input int sel);
        @(posedge clk);
        case (sel)
            // Remote terminal reset
            0: remoteResetIn <= 1'b1;
            // Stop key on the panel
            1: keyStopReset <= 1'b1;
            // Acknowledge key for the shown message
            default: keyAck <= 1'b1;
        endcase
        repeat (2) @(posedge clk);
        remoteResetIn <= 1'b0;
        keyStopReset <= 1'b0;
        keyAck <= 1'b0;
        // Released lines rest low so the next press is a fresh rising edge
        repeat (2) @(posedge clk);
        #1;
    endtask

    // Attach or pull the panel and pick the control location
    task automatic panel(input logic present, input logic loc);
        @(posedge clk);
        keypadPresent <= present;
        localControl <= loc;
    endtask
endmodule

// ==== dfl_pkg.sv ====
package dfl_pkg;

    // Clock and derived timing
    localparam int unsigned CLK_HZ = 25_000_000;
    // Comms timeout counts in milliseconds
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned MS_TICK_CYCLES = CLK_HZ / MS_PER_S;
    // Healthy_indicator indicator half period while fault_latched_flag
    localparam int unsigned BLINK_HALF_MS = 250;
    localparam int unsigned BLINK_HALF_CYCLES = MS_TICK_CYCLES * BLINK_HALF_MS;

    // Fault source indices; message code is index plus one
    localparam int NUM_FAULTS = 13;
    localparam int F_BUS_LOW = 0;
    localparam int F_BUS_HIGH = 1;
    localparam int F_OVER_CURRENT = 2;
    localparam int F_HEATSINK = 3;
    localparam int F_EXTERNAL = 4;
    localparam int F_AIN1_BREAK = 5;
    localparam int F_AIN2_BREAK = 6;
    localparam int F_STALL = 7;
    localparam int F_I2T = 8;
    localparam int F_BRAKE_RES = 9;
    localparam int F_BRAKE_SW = 10;
    localparam int F_KEYPAD = 11;
    localparam int F_COMMS = 12;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LATCH = 8'h04;
    localparam logic [7:0] OFS_SOURCE = 8'h08;
    localparam logic [7:0] OFS_COMMS_TO = 8'h0C;
    localparam logic [7:0] OFS_I2T_THRESH = 8'h10;
    localparam logic [7:0] OFS_I2T_UPPER = 8'h14;
    localparam logic [7:0] OFS_I2T_DUR = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_I2T_ACC = 8'h20;

    // Control field positions
    localparam int CTRL_INVERT_BIT = 0;
    localparam int CTRL_RUN_BIT = 1;
    // Status field positions
    localparam int ST_CODE_LSB = 0;
    localparam int ST_PEND_BIT = 4;
    localparam int ST_LATCHED_BIT = 5;
    localparam int ST_POWER_BIT = 6;

    // Reset values of writable registers
    localparam logic [15:0] RST_COMMS_TO = 16'h0000;
    localparam logic [15:0] RST_I2T_THRESH = 16'h8000;
    localparam logic [15:0] RST_I2T_UPPER = 16'hF000;
    localparam logic [31:0] RST_I2T_DUR = 32'h0100_0000;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== tb_drive_fault_latch_manager.sv ====
`timescale 1ns/1ns
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin num_errors++; \
$display("[FAIL] %s exp %0h seen %0h", n, e, s); end end

module tb_drive_fault_latch_manager;
    // Clock, reset, counters
    logic clk = 0;
    logic rst_b = 0;
    int num_errors = 0;
    int comparisons = 0;
    int seed = 98401;
    // Raw fault conditions by fault index
    logic [12:0] src = '0;
    // Register bus
    logic [7:0] awaddr = '0;
    logic [7:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d;
    // Drive side
    logic [15:0] motorCurrent = '0;
    logic commsValidPulse = 0;
    logic keypadPresent, localControl, remoteResetIn, keyStopReset, keyAck;
    logic powerEnable, healthLed, faultLatchedFlag, healthyOut, msgPending, p;
    logic [3:0] msgCode;
    int t;

    // Short counts keep the blink observable in a few dozen cycles
    dfl_fault_latch_manager #(.MS_TICK_CYCLES(4), .BLINK_HALF_CYCLES(8)) i_dut (
        .clk, .rst_b, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .dcBusLowDet(src[0]), .dcBusHighDet(src[1]), .overCurrentDet(src[2]),
        .heatsinkHotDet(src[3]), .extSupplyPresent(!src[4]), .ain1BreakDet(src[5]),
        .ain2BreakDet(src[6]), .stallDet(src[7]), .brakeResOverloadDet(src[9]),
        .brakeSwOverloadDet(src[10]), .motorCurrent, .commsValidPulse, .keypadPresent,
        .localControl, .remoteResetIn, .keyStopReset, .keyAck, .powerEnable, .healthLed,
        .faultLatchedFlag, .healthyOut, .msgCode, .msgPending);

    // Far side: panel keys and terminals
    dfl_keypad_panel_model i_pan (.clk, .remoteResetIn, .keyStopReset, .keyAck,
        .keypadPresent, .localControl);

    // Clock at 25 MHz
    initial
    begin
        forever #20 clk = ~clk;
    end

    // Random current below threshold; full scale forces the integral fault
    always @(posedge clk)
    begin
        motorCurrent <= src[8] ? 16'hFFFF : 16'($random(seed)) & 16'h7FFF;
        commsValidPulse <= 1'($random(seed)) & ~src[12];
    end

    task automatic results();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // A wait that ran out ends the run
    task automatic tmo(input int n);
        if (n >= 60)
        begin
            num_errors++;
            results();
        end
    endtask

    // Write: address and data offered together, each dropped once taken
    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while ((awvalid || wvalid || !bvalid) && n < 60)
        begin
            @(posedge clk);
            n++;
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        r = bresp;
        bready <= 1'b0;
        tmo(n);
    endtask

    task automatic axr(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (n < 60)
        begin
            @(posedge clk);
            n++;
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        tmo(n);
    endtask

    // Source high for two edges, then gone: only the latch remembers it
    task automatic trip(input int i);
        @(posedge clk);
        src[i] <= 1'b1;
        repeat (2) @(posedge clk);
        src[i] <= 1'b0;
        #1;
    endtask

    // Watchdog
    initial
    begin
        repeat (90000) @(posedge clk);
        num_errors++;
        results();
    end

    // Main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        `CHK("led", 1'b1, healthLed)
        axw(dfl_pkg::OFS_CTRL, 32'h2);
        axr(dfl_pkg::OFS_CTRL);
        `CHK("ctrl", 32'h2, d)
        `CHK("power", 1'b1, powerEnable)
        // Every detector in turn, reset from terminal or key at random
        for (int i = 0; i < 11; i++)
        begin
            trip(i);
            `CHK("power off", 1'b0, powerEnable)
            `CHK("flag", 1'b1, faultLatchedFlag)
            `CHK("healthy", 1'b0, healthyOut)
            `CHK("code", 4'(i + 1), msgCode)
            axr(dfl_pkg::OFS_LATCH);
            `CHK("latch", 32'h1 << i, d)
            i_pan.press($random(seed) & 1);
            `CHK("flag clr", 1'b0, faultLatchedFlag)
            `CHK("led on", 1'b1, healthLed)
            `CHK("power on", 1'b1, powerEnable)
            `CHK("healthy on", 1'b1, healthyOut)
            i_pan.press(2);
            `CHK("code clr", 4'h0, msgCode)
            `CHK("pend clr", 1'b0, msgPending)
        end
        // Heat fault arrives after the current fault stopped the stage
        @(posedge clk);
        src[2] <= 1'b1;
        @(posedge clk);
        src[3] <= 1'b1;
        src[2] <= 1'b0;
        repeat (2) @(posedge clk);
        i_pan.press(0);
        axr(dfl_pkg::OFS_LATCH);
        `CHK("latch kept", 32'h8, d)
        `CHK("power held", 1'b0, powerEnable)
        t = 0;
        p = healthLed;
        repeat (40)
        begin
            @(posedge clk);
            #1;
            if (healthLed !== p)
                t++;
            p = healthLed;
        end
        `CHK("blink", 1'b1, t >= 4)
        @(posedge clk);
        src[3] <= 1'b0;
        i_pan.press(1);
        axr(dfl_pkg::OFS_LATCH);
        `CHK("latch gone", 32'h0, d)
        i_pan.press(2);
        // Panel pulled while running locally
        i_pan.panel(1'b0, 1'b1);
        repeat (2) @(posedge clk);
        #1;
        `CHK("keypad code", 4'hC, msgCode)
        i_pan.panel(1'b1, 1'b0);
        i_pan.press(1);
        i_pan.press(2);
        // Traffic stops with a one millisecond timeout
        axw(dfl_pkg::OFS_COMMS_TO, 32'h1);
        src[12] <= 1'b1;
        repeat (12) @(posedge clk);
        axr(dfl_pkg::OFS_LATCH);
        `CHK("comms", 32'h1000, d)
        src[12] <= 1'b0;
        axw(dfl_pkg::OFS_COMMS_TO, 32'h0);
        i_pan.press(0);
        i_pan.press(2);
        // Inverted polarity while healthy
        axw(dfl_pkg::OFS_CTRL, 32'h3);
        repeat (2) @(posedge clk);
        #1;
        `CHK("inverted", 1'b0, healthyOut)
        // Unmapped place on both paths
        axr(8'h40);
        `CHK("rresp", dfl_pkg::RESP_SLVERR, r)
        `CHK("rdata", 32'h0, d)
        axw(8'h40, 32'hFFFF_FFFF);
        `CHK("bresp", dfl_pkg::RESP_SLVERR, r)
        // Only the low byte lane is written
        wstrb <= 4'h1;
        axw(dfl_pkg::OFS_I2T_THRESH, 32'hFFFF_FF12);
        axr(dfl_pkg::OFS_I2T_THRESH);
        `CHK("strobe", 32'h8012, d)
        results();
    end
endmodule
